// ### src/sip_pkg.sv
// Constants, states and timing for the sensor serial slave port.
// Assumes a 10 MHz system clock and a fast-mode bus master on the far side.
package sip_pkg;

  localparam logic [6:0] DEV_ADDR = 7'h64;
  localparam logic [7:0] ADDR_BYTE_WR = 8'hc8;
  localparam logic [7:0] ADDR_BYTE_RD = 8'hc9;
  localparam logic DIR_READ = 1'h1;
  localparam logic [7:0] REG_SOFT_RESET = 8'h0f;
  localparam int SOFT_RESET_BIT = 0;
  localparam logic [7:0] REG_FIFO_READ = 8'h60;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // Fast-mode clock low time, the shortest window for a crossing to settle
  localparam int SYS_CLK_KHZ = 10000;
  localparam int FAST_MODE_KBPS = 400;
  localparam int SCL_LOW_MIN_NS = 1300;
  localparam int SCL_LOW_CYCLES = (SCL_LOW_MIN_NS * SYS_CLK_KHZ) / 1000000;
  localparam int CROSS_CYCLES = 6;

  typedef enum logic [6:0] {
    ST_ADDR = 7'h01,
    ST_REG = 7'h02,
    ST_DHI = 7'h04,
    ST_DLO = 7'h08,
    ST_TXHI = 7'h10,
    ST_TXLO = 7'h20,
    ST_IGNORE = 7'h40
  } sip_state_type;

endpackage

// ### src/sip_port.sv
// Serial slave port giving the host access to every 16-bit sensor register.
// Assumes open-drain pins resolved outside, and a register file that answers
// reg_rd with reg_rdata on the following sys_clk cycle.
`timescale 1ns/1ps

module sip_port (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic link_scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata,
  output logic fifo_pop,
  output logic soft_reset
);

  if (sip_pkg::CROSS_CYCLES >= sip_pkg::SCL_LOW_CYCLES) begin : g_timing_check
    $error("System clock too slow for fast-mode bus timing");
  end

  // Synchroniser bits: link clock, data line, read, write and soft-reset toggles
  localparam int SYNC_W = 5;
  localparam int SY_SCL = 4;
  localparam int SY_SDA = 3;
  localparam int SY_RD = 2;
  localparam int SY_WR = 1;
  localparam int SY_SR = 0;
  // Pins reset to their idle high level, so no false start or stop follows reset
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 5'h18;

  logic [SYNC_W-1:0] sync_m;
  logic [SYNC_W-1:0] sync_s;
  logic [SYNC_W-1:0] sync_p;
  logic [SYNC_W-1:0] sync_edge;
  logic start_det;
  logic stop_det;
  logic frame_rst;
  logic link_rst;
  logic rd_fill;
  logic [15:0] rd_word;

  sip_pkg::sip_state_type state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] byte_now;
  logic ack_pend;
  logic [7:0] reg_ptr;
  logic [15:0] wr_word;
  logic rd_tog;
  logic wr_tog;
  logic sr_tog;
  logic [7:0] tx_byte;
  logic [2:0] tx_idx;

  // System side

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync_m <= SYNC_IDLE;
      sync_s <= SYNC_IDLE;
      sync_p <= SYNC_IDLE;
    end else begin
      sync_m <= {link_scl, sda_in, rd_tog, wr_tog, sr_tog};
      sync_s <= sync_m;
      sync_p <= sync_s;
    end
  end

  assign sync_edge = sync_s ^ sync_p;
  assign start_det = sync_s[SY_SCL] & sync_p[SY_SCL] & sync_p[SY_SDA] & ~sync_s[SY_SDA];
  assign stop_det = sync_s[SY_SCL] & sync_p[SY_SCL] & ~sync_p[SY_SDA] & sync_s[SY_SDA];

  // Frame reset holds the link logic idle from a start or stop until the
  // clock next falls; release always lands while the link clock is low.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      frame_rst <= 1'b1;
      link_rst <= 1'b1;
    end else begin
      link_rst <= 1'b0;
      if (start_det || stop_det) begin
        frame_rst <= 1'b1;
      end else if (!sync_s[SY_SCL]) begin
        frame_rst <= 1'b0;
      end
    end
  end

  // Strobes toward the register file; addresses and data are stable in the
  // link domain long before the toggle arrives here.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_addr <= 8'h00;
      reg_wdata <= 16'h0000;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      fifo_pop <= 1'b0;
      soft_reset <= 1'b0;
    end else begin
      reg_wr <= sync_edge[SY_WR];
      reg_rd <= sync_edge[SY_RD];
      fifo_pop <= sync_edge[SY_RD] && (reg_ptr == sip_pkg::REG_FIFO_READ);
      soft_reset <= sync_edge[SY_SR];
      if (sync_edge[SY_WR] || sync_edge[SY_RD]) begin
        reg_addr <= reg_ptr;
      end
      if (sync_edge[SY_WR]) begin
        reg_wdata <= wr_word;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_fill <= 1'b0;
      rd_word <= 16'h0000;
    end else begin
      rd_fill <= reg_rd;
      if (rd_fill) begin
        rd_word <= reg_rdata;
      end
    end
  end

  // The port never drives low except through the enable
  always_ff @(posedge sys_clk) begin
    sda_out <= 1'b0;
  end

  // Link side

  assign byte_now = {shift[6:0], sda_in};

  always_ff @(posedge link_scl or posedge frame_rst) begin
    if (frame_rst) begin
      state <= sip_pkg::ST_ADDR;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      ack_pend <= 1'b0;
    end else if (bit_cnt == sip_pkg::ACK_SLOT) begin
      bit_cnt <= 4'h0;
      ack_pend <= 1'b0;
      if (!ack_pend) begin
        unique case (state)
          sip_pkg::ST_TXHI: state <= sda_in ? sip_pkg::ST_IGNORE : sip_pkg::ST_TXLO;
          sip_pkg::ST_TXLO: state <= sip_pkg::ST_IGNORE;
          default: state <= state;
        endcase
      end
    end else begin
      shift <= byte_now;
      bit_cnt <= bit_cnt + 4'h1;
      if (bit_cnt == sip_pkg::LAST_BIT) begin
        unique case (state)
          sip_pkg::ST_ADDR: begin
            if (byte_now[7:1] == sip_pkg::DEV_ADDR) begin
              ack_pend <= 1'b1;
              state <= (byte_now[0] == sip_pkg::DIR_READ) ? sip_pkg::ST_TXHI : sip_pkg::ST_REG;
            end else begin
              state <= sip_pkg::ST_IGNORE;
            end
          end
          sip_pkg::ST_REG: begin
            ack_pend <= 1'b1;
            state <= sip_pkg::ST_DHI;
          end
          sip_pkg::ST_DHI: begin
            ack_pend <= 1'b1;
            state <= sip_pkg::ST_DLO;
          end
          sip_pkg::ST_DLO: begin
            ack_pend <= !((reg_ptr == sip_pkg::REG_SOFT_RESET) && byte_now[sip_pkg::SOFT_RESET_BIT]);
            state <= sip_pkg::ST_IGNORE;
          end
          sip_pkg::ST_TXHI, sip_pkg::ST_TXLO, sip_pkg::ST_IGNORE: state <= state;
        endcase
      end
    end
  end

  // Pointer, write word and toggles survive a repeated start
  always_ff @(posedge link_scl or posedge link_rst) begin
    if (link_rst) begin
      reg_ptr <= 8'h00;
      wr_word <= 16'h0000;
      rd_tog <= 1'b0;
      wr_tog <= 1'b0;
      sr_tog <= 1'b0;
    end else if (!frame_rst && bit_cnt == sip_pkg::LAST_BIT) begin
      if (state == sip_pkg::ST_REG) begin
        reg_ptr <= byte_now;
      end
      if (state == sip_pkg::ST_DHI) begin
        wr_word[15:8] <= byte_now;
      end
      if (state == sip_pkg::ST_ADDR && byte_now == sip_pkg::ADDR_BYTE_RD) begin
        rd_tog <= ~rd_tog;
      end
      if (state == sip_pkg::ST_DLO) begin
        if ((reg_ptr == sip_pkg::REG_SOFT_RESET) && byte_now[sip_pkg::SOFT_RESET_BIT]) begin
          sr_tog <= ~sr_tog;
        end else begin
          wr_word[7:0] <= byte_now;
          wr_tog <= ~wr_tog;
        end
      end
    end
  end

  assign tx_byte = (state == sip_pkg::ST_TXHI) ? rd_word[15:8] : rd_word[7:0];
  assign tx_idx = 3'(sip_pkg::LAST_BIT - bit_cnt);

  // Data line changes only while the clock is low; the clock is never driven
  always_ff @(negedge link_scl or posedge frame_rst) begin
    if (frame_rst) begin
      sda_oe <= 1'b0;
    end else if (bit_cnt == sip_pkg::ACK_SLOT) begin
      sda_oe <= ack_pend;
    end else if (state == sip_pkg::ST_TXHI || state == sip_pkg::ST_TXLO) begin
      sda_oe <= ~tx_byte[tx_idx];
    end else begin
      sda_oe <= 1'b0;
    end
  end

  // Checks on the system side

  chk_start_frame: assert property (@(posedge sys_clk) disable iff (sys_rst)
    start_det |=> frame_rst)
    else $error("Start did not reset the link logic");

  chk_frame_release: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (frame_rst && !sync_s[SY_SCL] && !start_det && !stop_det) |=> !frame_rst)
    else $error("Frame reset held after clock fell");

  chk_wr_single: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_wr |=> !reg_wr)
    else $error("Write strobe longer than one cycle");

  chk_fifo_pop_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
    fifo_pop |-> (reg_rd && reg_addr == sip_pkg::REG_FIFO_READ))
    else $error("FIFO pop without FIFO read");

  chk_rd_after_req: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $changed(sync_s[SY_RD]) |=> reg_rd ##2 (rd_word == $past(reg_rdata)))
    else $error("Read word not captured after request");

  chk_soft_no_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    soft_reset |-> !reg_wr)
    else $error("Software reset also produced a write");

  chk_stop_frame: assert property (@(posedge sys_clk) disable iff (sys_rst)
    stop_det |=> frame_rst)
    else $error("Stop did not reset the link logic");

  chk_rd_single: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_rd |=> !reg_rd)
    else $error("Read strobe longer than one cycle");

  chk_srst_single: assert property (@(posedge sys_clk) disable iff (sys_rst)
    soft_reset |=> !soft_reset)
    else $error("Software reset pulse longer than one cycle");

  chk_pop_on_fifo: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == sip_pkg::REG_FIFO_READ) |-> fifo_pop)
    else $error("FIFO read without pop");

  chk_wr_no_rd: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_wr |-> !reg_rd)
    else $error("Write and read strobes together");

  chk_wdata_word: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_wr |-> (reg_wdata == $past(wr_word)))
    else $error("Write word differs from received bytes");

  chk_addr_ptr: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (reg_wr || reg_rd) |-> (reg_addr == $past(reg_ptr)))
    else $error("Strobe address differs from register pointer");

  chk_rd_fill: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_rd |=> rd_fill)
    else $error("Read data capture not armed");

  // Checks on the link side

  chk_foreign_addr: assert property (@(posedge link_scl) disable iff (frame_rst)
    (state == sip_pkg::ST_ADDR && bit_cnt == sip_pkg::LAST_BIT
      && byte_now[7:1] != sip_pkg::DEV_ADDR) |=> (!ack_pend && state == sip_pkg::ST_IGNORE))
    else $error("Foreign address acknowledged");

  chk_soft_nack: assert property (@(posedge link_scl) disable iff (frame_rst)
    (state == sip_pkg::ST_DLO && bit_cnt == sip_pkg::LAST_BIT
      && reg_ptr == sip_pkg::REG_SOFT_RESET && byte_now[sip_pkg::SOFT_RESET_BIT])
      |=> !ack_pend)
    else $error("Software reset write acknowledged");

  chk_ignore_quiet: assert property (@(negedge link_scl) disable iff (frame_rst)
    (state == sip_pkg::ST_IGNORE && bit_cnt != sip_pkg::ACK_SLOT) |=> !sda_oe)
    else $error("Data line driven while ignoring");

  chk_own_ack: assert property (@(posedge link_scl) disable iff (frame_rst)
    (state == sip_pkg::ST_ADDR && bit_cnt == sip_pkg::LAST_BIT
      && byte_now == sip_pkg::ADDR_BYTE_WR) |=> (ack_pend && state == sip_pkg::ST_REG))
    else $error("Own write address not acknowledged");

  chk_dir_read: assert property (@(posedge link_scl) disable iff (frame_rst)
    (state == sip_pkg::ST_ADDR && bit_cnt == sip_pkg::LAST_BIT
      && byte_now == sip_pkg::ADDR_BYTE_RD) |=> (ack_pend && state == sip_pkg::ST_TXHI))
    else $error("Own read address not acknowledged");

  chk_reg_ack: assert property (@(posedge link_scl) disable iff (frame_rst)
    (state == sip_pkg::ST_REG && bit_cnt == sip_pkg::LAST_BIT)
      |=> (ack_pend && state == sip_pkg::ST_DHI))
    else $error("Register address not acknowledged");

  chk_hi_ack: assert property (@(posedge link_scl) disable iff (frame_rst)
    (state == sip_pkg::ST_DHI && bit_cnt == sip_pkg::LAST_BIT)
      |=> (ack_pend && state == sip_pkg::ST_DLO))
    else $error("Upper data byte not acknowledged");

  chk_master_nack: assert property (@(posedge link_scl) disable iff (frame_rst)
    (state == sip_pkg::ST_TXHI && bit_cnt == sip_pkg::ACK_SLOT && !ack_pend && sda_in)
      |=> state == sip_pkg::ST_IGNORE)
    else $error("Transmit went on after master not-acknowledge");

  chk_tx_end: assert property (@(posedge link_scl) disable iff (frame_rst)
    (state == sip_pkg::ST_TXLO && bit_cnt == sip_pkg::ACK_SLOT) |=> state == sip_pkg::ST_IGNORE)
    else $error("Transmit went past the lower byte");

  chk_ack_drive: assert property (@(negedge link_scl) disable iff (frame_rst)
    (bit_cnt == sip_pkg::ACK_SLOT && ack_pend) |=> sda_oe)
    else $error("Acknowledge not driven");

endmodule // sip_port

// ### sim/sip_host_model.sv
// Bus master model: drives the serial clock and pulls the data line low.
// Assumes an open-drain data line with pull-up; steps on sys_clk rising edges.
`timescale 1ns/1ps

module sip_host_model (
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Quarter bit of 7 cycles keeps the bus just under 400 kHz
  task automatic tick;
    repeat (7) @(posedge sys_clk);
  endtask

  task automatic start;
    sda_low <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda_low <= 1'b1;
    tick();
    scl <= 1'b0;
    tick();
  endtask

  task automatic stop;
    sda_low <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sda_low <= 1'b0;
    tick();
  endtask

  // High if the line was high at either of the two samples taken in the clock-high time
  task automatic bit_slot(input logic drive_low, output logic seen);
    sda_low <= drive_low;
    tick();
    scl <= 1'b1;
    tick();
    seen = sda_line;
    tick();
    seen = seen | sda_line;
    scl <= 1'b0;
    tick();
  endtask

  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(~b[i], s);
    end
    bit_slot(1'b0, s);
    ack = ~s;
  endtask

  task automatic recv(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b0, b[i]);
    end
    bit_slot(~last, s);
  endtask
endmodule // sip_host_model

// ### sim/tb.sv
// Testbench: register accesses over the serial port against a small register file.
// Assumes the port and the host model; link clock is the model's scl.
`timescale 1ns/1ps

module tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl, host_low, sda_out, sda_oe, reg_wr, reg_rd, fifo_pop, soft_reset;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [15:0] mem [256];
  int failures = 0, n_compared = 0, n_wr = 0, n_pop = 0, n_srst = 0;
  wire sda_line = ~(host_low | (sda_oe & ~sda_out));

  always #50 sys_clk = ~sys_clk;

  assign reg_rdata = (reg_addr === sip_pkg::REG_FIFO_READ) ? 16'hc3a5 : mem[reg_addr];
  always @(posedge sys_clk) begin
    if (reg_wr === 1'b1) begin
      mem[reg_addr] <= reg_wdata;
      n_wr <= n_wr + 1;
    end
    if (fifo_pop === 1'b1) n_pop <= n_pop + 1;
    if (soft_reset === 1'b1) n_srst <= n_srst + 1;
  end

  sip_port u_sip_port (.sys_clk(sys_clk), .sys_rst(sys_rst), .link_scl(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fifo_pop(fifo_pop), .soft_reset(soft_reset));
  sip_host_model u_sip_host_model (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl),
    .sda_low(host_low));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Acks packed as {extra, dev, reg, hi, lo}
  task automatic wr(input logic [7:0] dev, input logic [7:0] ra, input logic [15:0] d,
                    input logic xtra, output logic [4:0] a);
    a = 5'h00;
    u_sip_host_model.start();
    u_sip_host_model.send(dev, a[3]);
    u_sip_host_model.send(ra, a[2]);
    u_sip_host_model.send(d[15:8], a[1]);
    u_sip_host_model.send(d[7:0], a[0]);
    if (xtra) u_sip_host_model.send(8'h00, a[4]);
    u_sip_host_model.stop();
  endtask

  task automatic rd(input logic [7:0] ra, output logic [15:0] d, output logic [2:0] a);
    u_sip_host_model.start();
    u_sip_host_model.send(sip_pkg::ADDR_BYTE_WR, a[2]);
    u_sip_host_model.send(ra, a[1]);
    u_sip_host_model.start();
    u_sip_host_model.send(sip_pkg::ADDR_BYTE_RD, a[0]);
    u_sip_host_model.recv(1'b0, d[15:8]);
    u_sip_host_model.recv(1'b1, d[7:0]);
    u_sip_host_model.stop();
  endtask

  initial begin
    logic [4:0] a;
    logic [2:0] ra;
    logic [15:0] d;
    logic [7:0] foreign [2] = '{8'hca, 8'h48};
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wr(sip_pkg::ADDR_BYTE_WR, 8'h12, 16'hbeef, 1'b0, a);
    check("write acks", a, 5'h0f);
    wr(sip_pkg::ADDR_BYTE_WR, 8'h34, 16'h0180, 1'b1, a);
    check("extra byte acks", a, 5'h0f);
    check("write count", n_wr, 2);
    check("word 12", mem[8'h12], 16'hbeef);
    rd(8'h12, d, ra);
    check("read acks", ra, 3'h7);
    check("read 12", d, 16'hbeef);
    rd(8'h34, d, ra);
    check("read 34", d, 16'h0180);
    check("no pop", n_pop, 0);
    for (int i = 0; i < 2; i++) begin
      rd(sip_pkg::REG_FIFO_READ, d, ra);
      check("fifo word", d, 16'hc3a5);
      check("pop count", n_pop, i + 1);
    end
    foreach (foreign[i]) begin
      wr(foreign[i], 8'h12, 16'h0000, 1'b0, a);
      check("foreign acks", a, 5'h00);
    end
    check("foreign writes", n_wr, 2);
    wr(sip_pkg::ADDR_BYTE_WR, sip_pkg::REG_SOFT_RESET, 16'h0001, 1'b0, a);
    check("soft reset acks", a, 5'h0e);
    check("soft reset pulse", n_srst, 1);
    wr(sip_pkg::ADDR_BYTE_WR, sip_pkg::REG_SOFT_RESET, 16'h0000, 1'b0, a);
    check("plain reset reg acks", a, 5'h0f);
    check("soft reset idle", n_srst, 1);
    end_sim();
  end

  // Whole sequence needs about 12000 cycles
  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    end_sim();
  end
endmodule // tb
